// File: pmc_pkg.sv
// Package for the processor mode control register block
package pmc_pkg;
   localparam int unsigned REG_W          = 16;
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  MODE_REG_OFF   = 8'h00;
   localparam int unsigned PTR_HI         = 15;
   localparam int unsigned PTR_LO         = 7;
   localparam int unsigned PTR_W          = 9;
   localparam int unsigned ROM_SEL_BIT    = 6;
   localparam int unsigned OVERLAY_BIT    = 5;
   localparam int unsigned VIS_BIT        = 4;
   localparam int unsigned UPPER_MAP_BIT  = 3;
   localparam int unsigned CLK_OFF_BIT    = 2;
   localparam int unsigned MUL_SAT_BIT    = 1;
   localparam int unsigned ST_SAT_BIT     = 0;
   localparam logic [8:0]  PTR_RESET      = 9'h1ff;
   localparam logic [15:0] PAGE0_TOP      = 16'h007f;
   localparam logic [15:0] LOW_RAM_TOP    = 16'h7fff;
   localparam logic [15:0] UPPER_RAM_BASE = 16'h8000;
   localparam logic [15:0] ROM_BASE       = 16'hc000;
   localparam int unsigned VEC_SHIFT      = 2;
   localparam int unsigned CLK_DIV        = 2;

   typedef struct packed {
      logic [8:0] vector_page_pointer;
      logic       rom_map_select;
      logic       ram_overlay;
      logic       address_visibility;
      logic       upper_ram_data_map;
      logic       clock_output_off;
      logic       multiply_saturate;
      logic       store_saturate;
   } pmc_mode_t;

   typedef struct packed {
      logic       prog_rom_sel;
      logic       prog_ram_sel;
      logic       data_upper_sel;
   } pmc_decode_t;
endpackage

// File: pmc_clock_output_pin.sv
// Clock output divider with a hold-high disable
`timescale 1ns/1ns
`default_nettype none
module pmc_clock_output_pin
   import pmc_pkg::*;
#(
   parameter int unsigned DIV = CLK_DIV
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Control
   input  wire logic clock_output_off,
   // Pin
   output logic      clock_output_pin
);
   initial begin
      if (DIV < 2) $error("pmc_clock_output_pin: DIV must be at least 2");
   end

   logic [7:0] cnt;

   always_ff @(posedge clock) begin
      if (rst || cnt == 8'(DIV / 2 - 1)) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // Holding high avoids a runt low pulse when the pin is stopped
   always_ff @(posedge clock) begin
      if (rst) begin
         clock_output_pin <= 1'b1;
      end else if (clock_output_off) begin
         clock_output_pin <= 1'b1;
      end else if (cnt == 8'(DIV / 2 - 1)) begin
         clock_output_pin <= ~clock_output_pin;
      end
   end
endmodule
`default_nettype wire

// File: pmc_mode_reg.sv
// Processor mode control register with memory decode and pin control
//
// Overview of operation
// - Bits 15..7 hold a nine-bit pointer to the 128-word program page of the vectors.
// - Hardware reset sets the whole pointer to ones, so the reset vector sits at FF80h.
// - The software reset instruction leaves the pointer untouched.
// - Bit 6 at zero maps the on-chip ROM into program space, at one removes it.
// - Bit 6 is caught from the mode pin at hardware reset only, and software may change it.
// - Bit 5 at zero keeps dual-access RAM in data space only, at one also in program space.
// - Data page zero, 0h to 7Fh, never appears in program space even with overlay on.
// - Bit 4 at zero holds the address pins at the last address driven.
// - Bit 4 at one drives every internal program address with prog_valid high onto the address pins.
// - Bit 3 at one maps the upper four dual-access RAM blocks into data space.
// - Bit 2 at one stops the clock output pin and holds it high.
// - Bit 1 saturates the product before accumulate when overflow and fractional modes are on.
// - Bit 0 saturates accumulator data on store, after the store shift.
// - Each vector takes four words, so its address is page base plus four times its number.
`timescale 1ns/1ns
`default_nettype none
module pmc_mode_reg
   import pmc_pkg::*;
#(
   parameter int unsigned VEC_NUM_W = 5
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst,
   // Software reset instruction
   input  wire logic                soft_reset,
   // Mode pin, asynchronous
   input  wire logic                rom_select_pin,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [REG_W-1:0]    reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [REG_W-1:0]    reg_rdata,
   // Vector request
   input  wire logic                vec_req,
   input  wire logic [VEC_NUM_W-1:0] vec_num,
   output logic      [15:0]         vec_addr,
   // Program and data address decode
   input  wire logic [15:0]         prog_addr,
   input  wire logic                prog_valid,
   input  wire logic [15:0]         data_addr,
   output pmc_decode_t              decode,
   // External address pins
   output logic      [15:0]         ext_addr,
   // Arithmetic controls
   input  wire logic                overflow_mode,
   input  wire logic                fractional_mode,
   output logic                     mac_saturate,
   output logic                     store_saturate_en,
   output logic                     store_sat_after_shift,
   // Mode register view and clock pin
   output pmc_mode_t                mode,
   output logic                     clock_output_pin
);
   initial begin
      if (VEC_NUM_W < 1 || VEC_NUM_W > 5) $error("pmc_mode_reg: VEC_NUM_W must be 1..5");
   end

   // Two-stage synchroniser for the mode pin
   logic pin_meta;
   logic pin_sync;
   logic rst_d;

   always_ff @(posedge clock) begin
      pin_meta <= rom_select_pin;
      pin_sync <= pin_meta;
   end

   always_ff @(posedge clock) begin
      rst_d <= rst;
   end

   function automatic logic [REG_W-1:0] pack_mode(input pmc_mode_t m);
      logic [REG_W-1:0] v;
      v = '0;
      v[PTR_HI:PTR_LO]  = m.vector_page_pointer;
      v[ROM_SEL_BIT]    = m.rom_map_select;
      v[OVERLAY_BIT]    = m.ram_overlay;
      v[VIS_BIT]        = m.address_visibility;
      v[UPPER_MAP_BIT]  = m.upper_ram_data_map;
      v[CLK_OFF_BIT]    = m.clock_output_off;
      v[MUL_SAT_BIT]    = m.multiply_saturate;
      v[ST_SAT_BIT]     = m.store_saturate;
      return v;
   endfunction

   logic write_hit;
   assign write_hit = reg_write && reg_addr == MODE_REG_OFF;

   // Pointer: only hardware reset forces ones
   always_ff @(posedge clock) begin
      if (rst) begin
         mode.vector_page_pointer <= PTR_RESET;
      end else if (write_hit) begin
         mode.vector_page_pointer <= reg_wdata[PTR_HI:PTR_LO];
      end
      // Software reset does not touch the pointer
   end

   // Mode pin captured on the first cycle after reset release
   always_ff @(posedge clock) begin
      if (rst) begin
         mode.rom_map_select <= 1'b0;
      end else if (rst_d) begin
         mode.rom_map_select <= pin_sync;
      end else if (write_hit) begin
         mode.rom_map_select <= reg_wdata[ROM_SEL_BIT];
      end
   end

   // Remaining control bits
   always_ff @(posedge clock) begin
      if (rst) begin
         mode.ram_overlay        <= 1'b0;
         mode.address_visibility <= 1'b0;
         mode.upper_ram_data_map <= 1'b0;
         mode.clock_output_off   <= 1'b0;
         mode.multiply_saturate  <= 1'b0;
         mode.store_saturate     <= 1'b0;
      end else if (write_hit) begin
         mode.ram_overlay        <= reg_wdata[OVERLAY_BIT];
         mode.address_visibility <= reg_wdata[VIS_BIT];
         mode.upper_ram_data_map <= reg_wdata[UPPER_MAP_BIT];
         mode.clock_output_off   <= reg_wdata[CLK_OFF_BIT];
         mode.multiply_saturate  <= reg_wdata[MUL_SAT_BIT];
         mode.store_saturate     <= reg_wdata[ST_SAT_BIT];
      end
   end

   // Read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_read && reg_addr == MODE_REG_OFF) begin
         reg_rdata <= pack_mode(mode);
      end else begin
         reg_rdata <= '0;
      end
   end

   // Vector address: page base plus four words per vector
   always_ff @(posedge clock) begin
      if (rst) begin
         vec_addr <= {PTR_RESET, 7'h00};
      end else if (vec_req) begin
         vec_addr <= {mode.vector_page_pointer, 7'h00}
                   | 16'({vec_num, 2'b00});
      end
   end

   // Memory decode, registered so outputs come from flops
   logic next_rom;
   logic next_ram;
   logic next_upper;

   always_comb begin
      next_rom   = !mode.rom_map_select && prog_addr >= ROM_BASE;
      next_ram   = mode.ram_overlay && prog_addr > PAGE0_TOP
                && prog_addr <= LOW_RAM_TOP;
      next_upper = mode.upper_ram_data_map && data_addr >= UPPER_RAM_BASE;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         decode <= '0;
      end else begin
         decode.prog_rom_sel   <= next_rom;
         decode.prog_ram_sel   <= next_ram;
         decode.data_upper_sel <= next_upper;
      end
   end

   // Address pins follow fetches only in visibility mode
   always_ff @(posedge clock) begin
      if (rst) begin
         ext_addr <= '0;
      end else if (mode.address_visibility && prog_valid) begin
         ext_addr <= prog_addr;
      end
      // Otherwise the pins keep the last address driven
   end

   // Saturation controls for the datapath
   always_ff @(posedge clock) begin
      if (rst) begin
         mac_saturate          <= 1'b0;
         store_saturate_en     <= 1'b0;
         store_sat_after_shift <= 1'b0;
      end else begin
         mac_saturate <= mode.multiply_saturate && overflow_mode
                      && fractional_mode;
         store_saturate_en     <= mode.store_saturate;
         // Tells the store path to saturate the shifted value, not the raw one
         store_sat_after_shift <= mode.store_saturate;
      end
   end

   pmc_clock_output_pin #(
      .DIV (CLK_DIV)
   ) u_clock_output_pin (
      .clock            (clock),
      .rst              (rst),
      .clock_output_off (mode.clock_output_off),
      .clock_output_pin (clock_output_pin)
   );

   logic unused_soft;
   assign unused_soft = soft_reset;
endmodule
`default_nettype wire

// File: pmc_mode_reg_monitor.sv
// Assertions on the mode register ports
`timescale 1ns/1ns
`default_nettype none
module pmc_mode_reg_monitor
   import pmc_pkg::*;
#(
   parameter int unsigned VEC_NUM_W = 5
) (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 rst,
   // Register and vector port
   input wire logic [ADDR_W-1:0]    reg_addr,
   input wire logic [REG_W-1:0]     reg_wdata,
   input wire logic                 reg_write,
   input wire logic                 reg_read,
   input wire logic [REG_W-1:0]     reg_rdata,
   input wire logic                 vec_req,
   input wire logic [VEC_NUM_W-1:0] vec_num,
   input wire logic [15:0]          vec_addr,
   // Decode, pins and fields
   input wire logic [15:0]          prog_addr,
   input wire logic                 prog_valid,
   input wire logic [15:0]          data_addr,
   input wire logic                 overflow_mode,
   input wire logic                 fractional_mode,
   input wire logic                 mac_saturate,
   input wire logic                 store_saturate_en,
   input wire logic                 store_sat_after_shift,
   input wire pmc_decode_t          decode,
   input wire logic [15:0]          ext_addr,
   input wire pmc_mode_t            mode,
   input wire logic                 clock_output_pin
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_write_takes: assert property (reg_write && reg_addr == MODE_REG_OFF
      |=> mode == $past(reg_wdata)) else $error("write lost");
   a_read_value: assert property (reg_read |=> reg_rdata ==
      ($past(reg_addr) == MODE_REG_OFF ? {$past(mode)} : 16'h0000)) else $error("bad read");
   a_vector_addr: assert property (vec_req |=> vec_addr ==
      ({$past(mode.vector_page_pointer), 7'h00} | 16'({$past(vec_num), 2'b00})))
      else $error("bad vector");
   a_rom_decode: assert property (!$past(rst) |-> decode.prog_rom_sel ==
      $past(!mode.rom_map_select && prog_addr >= ROM_BASE)) else $error("bad rom map");
   a_ram_overlay: assert property (!$past(rst) |-> decode.prog_ram_sel ==
      $past(mode.ram_overlay && prog_addr > PAGE0_TOP && prog_addr <= LOW_RAM_TOP))
      else $error("bad overlay");
   a_addr_pins: assert property (!$past(rst) |-> ext_addr ==
      $past(mode.address_visibility && prog_valid ? prog_addr : ext_addr))
      else $error("bad address pins");
   a_clock_held: assert property (!$past(rst) && $past(mode.clock_output_off)
      |-> clock_output_pin) else $error("clock pin not high");
   a_clock_runs: assert property (!$past(rst) && !$past(mode.clock_output_off)
      |-> clock_output_pin != $past(clock_output_pin)) else $error("clock pin stuck");
   a_upper_map: assert property (!$past(rst) |-> decode.data_upper_sel ==
      $past(mode.upper_ram_data_map && data_addr >= UPPER_RAM_BASE)) else $error("bad upper map");
   a_mac_sat: assert property (!$past(rst) |-> mac_saturate ==
      $past(mode.multiply_saturate && overflow_mode && fractional_mode))
      else $error("bad multiply saturation");
   a_store_sat: assert property (!$past(rst) |-> store_saturate_en ==
      $past(mode.store_saturate) && store_sat_after_shift == $past(mode.store_saturate))
      else $error("bad store saturation");
   a_ptr_reset: assert property ($past(rst) |->
      mode.vector_page_pointer == PTR_RESET) else $error("pointer not all ones");
endmodule
bind pmc_mode_reg pmc_mode_reg_monitor #(.VEC_NUM_W(VEC_NUM_W)) pmc_mode_reg_monitor_inst (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vec_req(vec_req),
   .vec_num(vec_num), .vec_addr(vec_addr), .prog_addr(prog_addr), .prog_valid(prog_valid),
   .decode(decode), .ext_addr(ext_addr), .mode(mode), .clock_output_pin(clock_output_pin),
   .data_addr(data_addr), .overflow_mode(overflow_mode), .fractional_mode(fractional_mode),
   .mac_saturate(mac_saturate), .store_saturate_en(store_saturate_en),
   .store_sat_after_shift(store_sat_after_shift));
`default_nettype wire

// File: tb_processor_mode_control_register.sv
// Self-checking bench for the mode register
`timescale 1ns/1ns
`default_nettype none
module tb_processor_mode_control_register
   import pmc_pkg::*;
;
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
   logic        clock, rst, soft_reset, rom_select_pin, reg_write, reg_read;
   logic        vec_req, prog_valid, overflow_mode, fractional_mode, clk_pin;
   logic        rd_d = 1'b0;
   logic [7:0]  reg_addr;
   logic [4:0]  vec_num;
   logic [15:0] reg_wdata, reg_rdata, vec_addr, prog_addr, data_addr, w;
   logic [15:0] lf = 16'h000c;
   logic [15:0] q[$];
   int          fails = 0;
   int          n_tests = 0;
   pmc_mode_reg pmc_mode_reg_inst (.clock(clock), .rst(rst), .soft_reset(soft_reset),
      .rom_select_pin(rom_select_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vec_req(vec_req),
      .vec_num(vec_num), .vec_addr(vec_addr), .prog_addr(prog_addr), .prog_valid(prog_valid),
      .data_addr(data_addr), .decode(), .ext_addr(), .overflow_mode(overflow_mode),
      .fractional_mode(fractional_mode), .mac_saturate(), .store_saturate_en(),
      .store_sat_after_shift(), .mode(), .clock_output_pin(clk_pin));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [15:0] d);
      @(posedge clock);
      reg_write <= wr;
      reg_read  <= rd;
      reg_addr  <= a;
      reg_wdata <= d;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [15:0] e);
      q.push_back(e);
      bus(1'b0, 1'b1, a, 16'h0000);
   endtask
   task automatic vq(input logic [4:0] n, input logic [15:0] e);
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      vec_req <= 1'b1;
      vec_num <= n;
      @(posedge clock);
      vec_req <= 1'b0;
      #1;
      `CK(vec_addr, e)
   endtask
   always #5 clock = ~clock;
   // Free-running traffic keeps every decode path busy
   always @(posedge clock) begin
      lf <= nx(lf);
      prog_addr <= lf;
      data_addr <= ~lf;
      {prog_valid, overflow_mode, fractional_mode} <= lf[2:0];
   end
   always @(posedge clock) begin
      if (rd_d) begin
         `CK(reg_rdata, q.pop_front())
      end
      rd_d = reg_read;
   end
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      conclude;
   end
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      rom_select_pin = 1'b1;
      {reg_write, reg_read, vec_req, soft_reset} = '0;
      {reg_addr, reg_wdata, vec_num} = '0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rdx(MODE_REG_OFF, 16'hffc0);
      vq(5'h1f, 16'hfffc);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         w = lf;
         bus(1'b1, 1'b0, MODE_REG_OFF, w);
         rdx(MODE_REG_OFF, w);
         vq(lf[4:0], {w[15:7], 7'h00} | {9'h000, lf[4:0], 2'b00});
      end
      $display("random test done");
      bus(1'b1, 1'b0, 8'h01, ~w);
      rdx(8'h01, 16'h0000);
      rdx(MODE_REG_OFF, w);
      soft_reset <= 1'b1;
      rom_select_pin <= ~w[6];
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      soft_reset <= 1'b0;
      repeat (4) @(posedge clock);
      rdx(MODE_REG_OFF, w);
      bus(1'b1, 1'b0, MODE_REG_OFF, 16'h0004);
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      repeat (3) @(posedge clock);
      #1;
      `CK(clk_pin, 1'b1)
      $display("refusal and clock test done");
      conclude;
   end
endmodule
`default_nettype wire
